/* hdl/pdc_map.vh */
// power-down pin state control: constants
// assumes inclusion by pdc_top.v and pdc_sync.v
`ifndef PDC_MAP_VH
`define PDC_MAP_VH
`define PDC_ST_RUN     3'h1
`define PDC_ST_SLEEP   3'h2
`define PDC_ST_WAKE    3'h4
`define PDC_IDX_RUN    0
`define PDC_IDX_SLEEP  1
`define PDC_IDX_WAKE   2
`define PDC_WAKE_NS    100
`define PDC_CLK_NS     10
`define PDC_WAKE_CYC   ((`PDC_WAKE_NS + `PDC_CLK_NS - 1) / `PDC_CLK_NS)
`define PDC_CNT_W      4
`define PDC_SYNC_W     5
`define PDC_ZERO1      1'h0
`define PDC_ONE1       1'h1
`define PDC_ZERO8      8'h00
`endif

/* hdl/pdc_sync.v */
// power-down pin state control: two-flop synchronisers for pin inputs
// assumes pins are asynchronous to ref_clk_in
`timescale 1ns/1ps
`include "pdc_map.vh"
module pdc_sync #(
  parameter WIDTH = `PDC_SYNC_W
) (
  input  wire             ref_clk_in,
  input  wire             rst_in,
  input  wire [WIDTH-1:0] async_in,
  input  wire [WIDTH-1:0] reset_val_in,
  output reg  [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta;
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge ref_clk_in) begin
        if (rst_in) begin
          meta[i]     <= reset_val_in[i];
          sync_out[i] <= reset_val_in[i];
        end else begin
          meta[i]     <= async_in[i];
          sync_out[i] <= meta[i];
        end
      end
    end
  endgenerate
endmodule // pdc_sync

/* hdl/pdc_top.v */
// power-down pin state control for an optical motion sensor
// assumes ref_clk_in is the internal oscillator; pins are asynchronous
// Function
// R1 - a low level on power_down_n_input requests entry to power-down.
// R2 - in power-down the oscillator is halted and all registers hold.
// R3 - in power-down every output is driven low or released to hi-Z; the code drives the laser pins and low_power_sleep_mode_out high.
// R4 - power-down parks serial and laser pins, reset stays live, wake restores.
// R5 - device registers are reached only over the serial port.
// R6 - the host must pulse reset after every power-up to reach a known state.
// R7 - when power-down is released the oscillator and serial inputs resume.
`timescale 1ns/1ps
`include "pdc_map.vh"
module pdc_top (
  input  wire ref_clk_in,
  input  wire rst_in,
  input  wire power_down_n_input_in,
  input  wire serial_select_n_in,
  input  wire sclk_in,
  input  wire mosi_in,
  input  wire core_miso_in,
  input  wire core_miso_drive_in,
  input  wire core_pullup_en_in,
  input  wire core_laser_drive_in,
  input  wire core_laser_enable_n_in,
  output reg  osc_enable_out,
  output reg  core_clk_en_out,
  output reg  low_power_sleep_mode_out,
  output reg  pullup_en_out,
  output reg  sclk_out,
  output reg  mosi_out,
  output reg  miso_out,
  output reg  miso_oe_n_out,
  output reg  laser_drive_output_out,
  output reg  laser_enable_n_output_out
);
  wire [`PDC_SYNC_W-1:0] pin_sync;
  reg  [2:0]             state;
  reg  [2:0]             next_state;
  reg  [`PDC_CNT_W-1:0]  wake_cnt;
  reg                    pullup_saved;
  wire                   pd_req;
  wire                   sel_n;
  wire                   asleep;
  pdc_sync #(
    .WIDTH        (`PDC_SYNC_W)
  ) u_sync (
    .ref_clk_in   (ref_clk_in),
    .rst_in       (rst_in),
    .async_in     ({mosi_in, sclk_in, serial_select_n_in,
                    `PDC_ONE1, power_down_n_input_in}),
    .reset_val_in ({`PDC_ZERO1, `PDC_ZERO1, `PDC_ONE1,
                    `PDC_ONE1, `PDC_ONE1}),
    .sync_out     (pin_sync)
  );
  assign pd_req = ~pin_sync[0]; // R1
  assign sel_n  = pin_sync[2];
  assign asleep = ~state[`PDC_IDX_RUN];
  // sleep state machine
  always @* begin
    next_state = state;
    case (state)
      `PDC_ST_RUN:   if (pd_req) next_state = `PDC_ST_SLEEP; // R1
      `PDC_ST_SLEEP: if (!pd_req) next_state = `PDC_ST_WAKE; // R7
      `PDC_ST_WAKE: begin
        if (pd_req)
          next_state = `PDC_ST_SLEEP;
        else if (wake_cnt == `PDC_WAKE_CYC - 1)
          next_state = `PDC_ST_RUN; // R7
      end
      default:       next_state = `PDC_ST_RUN;
    endcase
  end
  // reset stays live in every state
  always @(posedge ref_clk_in) begin
    if (rst_in) begin // R4
      state    <= `PDC_ST_RUN;
      wake_cnt <= {`PDC_CNT_W{1'b0}};
    end else begin
      state <= next_state;
      if (next_state == `PDC_ST_WAKE)
        wake_cnt <= wake_cnt + 1'b1;
      else
        wake_cnt <= {`PDC_CNT_W{1'b0}};
    end
  end
  // pull-up state saved on entry, restored on wake
  always @(posedge ref_clk_in) begin
    if (rst_in)
      pullup_saved <= `PDC_ONE1;
    else if (state[`PDC_IDX_RUN] && pd_req)
      pullup_saved <= core_pullup_en_in; // R4
  end
  // pin outputs
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      osc_enable_out            <= `PDC_ONE1;
      core_clk_en_out           <= `PDC_ZERO1;
      low_power_sleep_mode_out  <= `PDC_ZERO1;
      pullup_en_out             <= `PDC_ONE1;
      sclk_out                  <= `PDC_ZERO1;
      mosi_out                  <= `PDC_ZERO1;
      miso_out                  <= `PDC_ZERO1;
      miso_oe_n_out             <= `PDC_ONE1;
      laser_drive_output_out    <= `PDC_ONE1;
      laser_enable_n_output_out <= `PDC_ONE1;
    end else if (asleep || pd_req) begin
      osc_enable_out            <= state[`PDC_IDX_WAKE] & ~pd_req; // R2
      core_clk_en_out           <= `PDC_ZERO1; // R2
      low_power_sleep_mode_out  <= `PDC_ONE1;
      pullup_en_out             <= state[`PDC_IDX_WAKE] & ~pd_req &
                                   pullup_saved; // R4
      sclk_out                  <= `PDC_ZERO1; // R4
      mosi_out                  <= `PDC_ZERO1; // R4
      miso_out                  <= `PDC_ZERO1; // R3
      miso_oe_n_out             <= sel_n; // R4
      laser_drive_output_out    <= `PDC_ONE1; // R4
      laser_enable_n_output_out <= `PDC_ONE1; // R4
    end else begin
      osc_enable_out            <= `PDC_ONE1; // R7
      core_clk_en_out           <= `PDC_ONE1; // R7
      low_power_sleep_mode_out  <= `PDC_ZERO1;
      pullup_en_out             <= core_pullup_en_in;
      sclk_out                  <= pin_sync[3]; // R5
      mosi_out                  <= pin_sync[4]; // R5
      miso_out                  <= core_miso_in;
      miso_oe_n_out             <= sel_n | ~core_miso_drive_in;
      laser_drive_output_out    <= core_laser_drive_in;
      laser_enable_n_output_out <= core_laser_enable_n_in;
    end
  end
endmodule // pdc_top

/* testbench/pdc_checker.sv */
// pdc checker: power-down pin states seen at pdc_top ports
// assumes binding onto pdc_top, single clock domain
`timescale 1ns/1ps
module pdc_checker (
  input wire ref_clk_in,
  input wire rst_in,
  input wire power_down_n_input_in,
  input wire osc_enable_out,
  input wire core_clk_en_out,
  input wire low_power_sleep_mode_out,
  input wire pullup_en_out,
  input wire sclk_out,
  input wire mosi_out,
  input wire miso_out,
  input wire laser_drive_output_out,
  input wire laser_enable_n_output_out
);
  wire pd = power_down_n_input_in;
  wire slp = low_power_sleep_mode_out;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  a_sleep_entry: assert property (!pd[*4] |-> slp)
    else $error("sleep not entered");
  a_osc_halted: assert property (!pd[*4] |-> !osc_enable_out
    && !core_clk_en_out) else $error("clock not halted");
  a_outputs_low: assert property (!pd[*4] |->
    !miso_out && !pullup_en_out) else $error("output not low");
  a_laser_off: assert property (!pd[*4] |-> laser_drive_output_out
    && laser_enable_n_output_out && !sclk_out && !mosi_out)
    else $error("pins not parked");
  a_wake_hold: assert property ($rose(osc_enable_out) |->
    (slp && !core_clk_en_out)[*8]) else $error("wake too short");
  a_resume_run: assert property ($rose(osc_enable_out) ##1 pd[*8]
    ##1 pd[*2] |-> !slp && core_clk_en_out) else $error("no resume");
  c_sleep: cover property (!pd[*4]);
  c_wake: cover property ($rose(osc_enable_out));
  c_run: cover property (pd[*8]);
endmodule // pdc_checker
bind pdc_top pdc_checker chk_u (.*);

/* testbench/pdc_host.sv */
// pdc host model: drives reset, power-down and serial pins
// assumes bench sets its inputs by non-blocking at the falling edge
`timescale 1ns/1ps
module pdc_host (
  input  wire       ref_clk_in,
  input  wire       sleep_req_in,
  input  wire [7:0] data_in,
  output reg        rst_out = 1'h1,
  output reg        power_down_n_out = 1'h1,
  output reg        serial_select_n_out = 1'h1,
  output reg        sclk_out = 1'h0,
  output reg        mosi_out = 1'h0
);
  integer n = 0;
  always @(negedge ref_clk_in) begin
    n <= n + 1;
    rst_out <= n < 5;
    power_down_n_out <= !sleep_req_in;
    serial_select_n_out <= data_in[7];
    sclk_out <= !data_in[7] && !sclk_out;
    mosi_out <= data_in[7] ? !mosi_out : data_in[0];
  end
endmodule // pdc_host

/* testbench/pdc_tb_top.sv */
// pdc bench: host model drives pins, steady states checked
// assumes pdc_top, pdc_host and pdc_checker are compiled
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_compared++; if ((e) !== (s)) begin \
  mismatches++; $display("Error %s exp %0h got %0h", n, e, s); end end
module pdc_tb_top;
  reg ref_clk_in = 0, sleep_req = 0;
  reg [7:0] data = 8'h00;
  reg [4:0] cfg = 5'h1f;
  reg [2:0] p1 = 3'h4, p2 = 3'h4;
  wire rst, pdn, ssn, sck, sdi, osc, cke, slp, pu, so, mo, mi, moe, ld, le;
  integer mismatches = 0, n_compared = 0, lo = 0, hi = 0, cyc = 0;
  integer saved = -1, i, j;
  always #5 ref_clk_in = ~ref_clk_in;
  pdc_host host_u (.ref_clk_in(ref_clk_in), .sleep_req_in(sleep_req),
    .data_in(data), .rst_out(rst), .power_down_n_out(pdn),
    .serial_select_n_out(ssn), .sclk_out(sck), .mosi_out(sdi));
  pdc_top dut_u (.ref_clk_in(ref_clk_in), .rst_in(rst),
    .power_down_n_input_in(pdn), .serial_select_n_in(ssn), .sclk_in(sck),
    .mosi_in(sdi), .core_miso_in(cfg[0]), .core_miso_drive_in(cfg[1]),
    .core_pullup_en_in(cfg[2]), .core_laser_drive_in(cfg[3]),
    .core_laser_enable_n_in(cfg[4]), .osc_enable_out(osc),
    .core_clk_en_out(cke), .low_power_sleep_mode_out(slp),
    .pullup_en_out(pu), .sclk_out(so), .mosi_out(mo), .miso_out(mi),
    .miso_oe_n_out(moe), .laser_drive_output_out(ld),
    .laser_enable_n_output_out(le));
  task report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 1500) begin
      mismatches++;
      report_and_stop;
    end
  end
  initial begin
    i = $urandom(79823);
    for (i = 0; i < 40; i++) begin
      sleep_req <= $urandom % 2;
      cfg <= $urandom;
      for (j = 0; j < 24; j++) begin
        @(negedge ref_clk_in);
        lo = pdn ? 0 : lo + 1;
        hi = pdn ? hi + 1 : 0;
        if (lo == 1) saved = cfg[2];
        if (lo >= 4) begin
          `CHK("sleep", 1'b1, slp)
          `CHK("clocks", 2'b00, {osc, cke})
          `CHK("quiet", 2'b00, {pu, mi})
          `CHK("pins", 4'b1100, {ld, le, so, mo})
          `CHK("miso_oe", p2[2], moe)
        end
        if (hi > 4 && hi < 10 && saved >= 0)
          `CHK("restore", saved[0], pu)
        if (hi >= 16 && j >= 8)
          `CHK("run", {3'b011, cfg[4:2]}, {slp, osc, cke, le, ld, pu})
        if (hi >= 16 && j >= 8)
          `CHK("serial", {p2[2] | ~cfg[1], cfg[0], p2[1:0]}, {moe, mi, so, mo})
        p2 = p1;
        p1 = {ssn, sck, sdi};
        data <= $urandom;
      end
    end
    report_and_stop;
  end
endmodule // pdc_tb_top
